// [hw/eeprom_pwr_pkg.sv]
// Purpose: Shared constants for the EEPROM power-up and write-launch logic
// Assumes: 40 MHz reference clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words

package eeprom_pwr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0]  ADDR_STATUS   = 8'h00;
   localparam logic [7:0]  ADDR_CTRL     = 8'h04;
   localparam logic [7:0]  ADDR_LAST     = 8'h08;
   localparam logic [7:0]  ADDR_ARRAY    = 8'h0C;

   // Status word fields
   localparam int          STAT_WIP      = 0;
   localparam int          STAT_WEL      = 1;
   localparam int          STAT_BPL      = 2;
   localparam int          STAT_BPH      = 3;
   localparam int          STAT_STATUS_WRITE_DISABLE     = 7;
   localparam int          STAT_SEL      = 8;
   localparam int          STAT_PAUSE    = 9;
   localparam int          STAT_STANDBY  = 10;

   // Control word fields and reset value
   localparam int          CTRL_PAUSE_EN = 0;
   localparam int          CTRL_ACCEPT   = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h3;

   // Positions inside the status-write data byte
   localparam int          DAT_STATUS_WRITE_DISABLE      = 7;
   localparam int          DAT_BPH       = 3;
   localparam int          DAT_BPL       = 2;

   // Delivery contents
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
   localparam logic [2:0]  NV_FACTORY    = 3'h0;

   // Frame lengths in bytes, opcode included
   localparam logic [2:0]  LEN_CMD_ONLY  = 3'h1;
   localparam logic [2:0]  LEN_STATUS_WR = 3'h2;
   localparam logic [2:0]  LEN_ARRAY_WR  = 3'h4;

   // Self-timed write cycle
   localparam int          T_WRITE_NS    = 5000000;
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          WRITE_CYCLES  = T_WRITE_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } wr_state_e;

endpackage

// [hw/eeprom_pwr_seq.sv]
// Purpose: Power-up state and write-cycle launch of a serial EEPROM
// Assumes: RST_N is the power-on reset, APB master on REF_CLK
// Notes:   Array contents are not stored here, reads show the erased value
`timescale 1ns/10ps
`default_nettype none

module eeprom_pwr_seq #(
   parameter int         WRITE_CYCLES = eeprom_pwr_pkg::WRITE_CYCLES,
   parameter logic [7:0] OP_WRITE     = 8'h02,
   parameter logic [7:0] OP_STAT_WR   = 8'h01,
   parameter logic [7:0] OP_LATCH_SET = 8'h06,
   parameter logic [7:0] OP_LATCH_CLR = 8'h04,
   parameter logic [7:0] OP_ID_WRITE  = 8'h82,
   parameter logic [7:0] OP_ID_LOCK   = 8'h83
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        SPI_SCK,
   input  wire logic        SPI_CS_N,
   input  wire logic        SPI_MOSI,
   input  wire logic        SPI_HOLD_N,
   output logic             STANDBY,
   output logic             WRITE_BUSY
);

   localparam int TW_W = $clog2(WRITE_CYCLES + 1);

   logic [7:0]                  rx_byte;
   logic                        rx_toggle;
   logic                        cs_meta, cs_sync, cs_prev;
   logic                        hold_meta, hold_sync;
   logic                        tog_meta, tog_sync, tog_prev;
   logic                        cs_fall, cs_rise, byte_evt;
   logic                        selected, paused, frame_end;
   logic [2:0]                  byte_cnt;
   logic [7:0]                  opcode, data1, op_busy;
   logic                        write_enable_latch;
   logic [1:0]                  ctrl;
   eeprom_pwr_pkg::wr_state_e   state;
   logic [TW_W-1:0]             tw_cnt;
   logic [7:0]                  nv_data;
   logic [2:0]                  nv_bits;
   logic                        launch, write_done, nv_load;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Decoded opcodes that start an internal write, with enough bytes
   function automatic logic starts_write(input logic [7:0] op, input logic [2:0] cnt);
      logic arr;
      arr = (op == OP_WRITE) || (op == OP_ID_WRITE) || (op == OP_ID_LOCK);
      return (arr && cnt >= eeprom_pwr_pkg::LEN_ARRAY_WR) ||
             (op == OP_STAT_WR && cnt >= eeprom_pwr_pkg::LEN_STATUS_WR);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return a == eeprom_pwr_pkg::ADDR_STATUS || a == eeprom_pwr_pkg::ADDR_CTRL ||
             a == eeprom_pwr_pkg::ADDR_LAST || a == eeprom_pwr_pkg::ADDR_ARRAY;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Link side

   spi_link_rx u_link (
      .sck       (SPI_SCK),
      .cs_n      (SPI_CS_N),
      .mosi      (SPI_MOSI),
      .rx_byte   (rx_byte),
      .rx_toggle (rx_toggle)
   );

   // Two-stage synchronisers; select stages reset low so a frame open at release shows no fall
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         cs_meta   <= 1'b0;
         cs_sync   <= 1'b0;
         cs_prev   <= 1'b0;
         hold_meta <= 1'b1;
         hold_sync <= 1'b1;
         tog_meta  <= 1'b0;
         tog_sync  <= 1'b0;
         tog_prev  <= 1'b0;
      end else begin
         cs_meta   <= SPI_CS_N;
         cs_sync   <= cs_meta;
         cs_prev   <= cs_sync;
         hold_meta <= SPI_HOLD_N;
         hold_sync <= hold_meta;
         tog_meta  <= rx_toggle;
         tog_sync  <= tog_meta;
         tog_prev  <= tog_sync;
      end
   end

   assign cs_fall  = cs_prev & ~cs_sync;
   assign cs_rise  = ~cs_prev & cs_sync;
   assign byte_evt = tog_sync ^ tog_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Selection and pause

   // A frame already running at power-up is ignored
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         selected <= 1'b0;
      end else if (cs_fall && ctrl[eeprom_pwr_pkg::CTRL_ACCEPT]) begin
         selected <= 1'b1;
      end else if (cs_rise) begin
         selected <= 1'b0;
      end
   end

   // Pause only ever follows a live hold request inside a frame
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         paused <= 1'b0;
      end else begin
         paused <= selected & ctrl[eeprom_pwr_pkg::CTRL_PAUSE_EN] & ~hold_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame capture

   // Byte word is stable for a whole byte time, the toggle qualifies it
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         byte_cnt  <= 3'h0;
         opcode    <= 8'h00;
         data1     <= 8'h00;
         frame_end <= 1'b0;
      end else begin
         // Delayed a cycle so a last byte seen together with deselect counts
         frame_end <= cs_rise & selected;
         if (cs_fall) begin
            byte_cnt <= 3'h0;
         end else if (byte_evt && selected && !paused) begin
            if (byte_cnt == 3'h0) begin
               opcode <= rx_byte;
            end
            if (byte_cnt == eeprom_pwr_pkg::LEN_STATUS_WR - 3'h1) begin
               data1 <= rx_byte;
            end
            if (byte_cnt != 3'h7) begin
               byte_cnt <= byte_cnt + 3'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write enable latch and write engine

   // Lock refused while every block is protected
   assign launch = frame_end && state == eeprom_pwr_pkg::ST_IDLE && write_enable_latch &&
                   starts_write(opcode, byte_cnt) &&
                   !(opcode == OP_ID_LOCK && nv_bits[1:0] == 2'h3);
   assign write_done = state == eeprom_pwr_pkg::ST_BUSY && tw_cnt == '0;
   assign nv_load    = write_done && op_busy == OP_STAT_WR;

   // Latch opens for one write only
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         write_enable_latch <= 1'b0;
      end else if (write_done) begin
         write_enable_latch <= 1'b0;
      end else if (frame_end && state == eeprom_pwr_pkg::ST_IDLE &&
                   byte_cnt >= eeprom_pwr_pkg::LEN_CMD_ONLY) begin
         if (opcode == OP_LATCH_SET) begin
            write_enable_latch <= 1'b1;
         end else if (opcode == OP_LATCH_CLR) begin
            write_enable_latch <= 1'b0;
         end
      end
   end

   // Self-timed write cycle
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         state      <= eeprom_pwr_pkg::ST_IDLE;
         WRITE_BUSY <= 1'b0;
         tw_cnt     <= '0;
         op_busy    <= 8'h00;
         nv_data    <= 8'h00;
      end else begin
         unique case (state)
            eeprom_pwr_pkg::ST_IDLE: begin
               if (launch) begin
                  state      <= eeprom_pwr_pkg::ST_BUSY;
                  WRITE_BUSY <= 1'b1;
                  tw_cnt     <= TW_W'(WRITE_CYCLES - 1);
                  op_busy    <= opcode;
                  nv_data    <= data1;
               end
            end
            eeprom_pwr_pkg::ST_BUSY: begin
               if (tw_cnt == '0) begin
                  state      <= eeprom_pwr_pkg::ST_IDLE;
                  WRITE_BUSY <= 1'b0;
               end else begin
                  tw_cnt <= tw_cnt - TW_W'(1);
               end
            end
            default: begin
               state      <= eeprom_pwr_pkg::ST_IDLE;
               WRITE_BUSY <= 1'b0;
            end
         endcase
      end
   end

   // Power-up reset never reaches these cells
   nv_status_store u_nv (
      .clk  (REF_CLK),
      .load (nv_load),
      .din  ({nv_data[eeprom_pwr_pkg::DAT_STATUS_WRITE_DISABLE], nv_data[eeprom_pwr_pkg::DAT_BPH],
              nv_data[eeprom_pwr_pkg::DAT_BPL]}),
      .bits (nv_bits)
   );

   // Standby whenever idle and not selected; drops together with the write launch
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         STANDBY <= 1'b1;
      end else begin
         STANDBY <= ~selected & ~launch & (state == eeprom_pwr_pkg::ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, no wait states: answer registered in the setup cycle

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY <= PSEL & ~PENABLE;
         if (PSEL && !PENABLE) begin
            PSLVERR <= ~is_mapped(PADDR);
            PRDATA  <= 32'h0000_0000;
            if (!PWRITE) begin
               unique case (PADDR)
                  eeprom_pwr_pkg::ADDR_STATUS: begin
                     PRDATA[eeprom_pwr_pkg::STAT_WIP]     <= WRITE_BUSY;
                     PRDATA[eeprom_pwr_pkg::STAT_WEL]     <= write_enable_latch;
                     PRDATA[eeprom_pwr_pkg::STAT_BPL]     <= nv_bits[0];
                     PRDATA[eeprom_pwr_pkg::STAT_BPH]     <= nv_bits[1];
                     PRDATA[eeprom_pwr_pkg::STAT_STATUS_WRITE_DISABLE]    <= nv_bits[2];
                     PRDATA[eeprom_pwr_pkg::STAT_SEL]     <= selected;
                     PRDATA[eeprom_pwr_pkg::STAT_PAUSE]   <= paused;
                     PRDATA[eeprom_pwr_pkg::STAT_STANDBY] <= STANDBY;
                  end
                  eeprom_pwr_pkg::ADDR_CTRL: begin
                     PRDATA[1:0] <= ctrl;
                  end
                  eeprom_pwr_pkg::ADDR_LAST: begin
                     PRDATA[18:0] <= {byte_cnt, opcode, op_busy};
                  end
                  eeprom_pwr_pkg::ADDR_ARRAY: begin
                     PRDATA <= {4{eeprom_pwr_pkg::ERASED_BYTE}};
                  end
                  default: begin
                     PRDATA <= 32'h0000_0000;
                  end
               endcase
            end
         end
      end
   end

   // Control write lands on the completing access edge
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ctrl <= eeprom_pwr_pkg::CTRL_RESET;
      end else if (PSEL && PENABLE && PREADY && PWRITE &&
                   PADDR == eeprom_pwr_pkg::ADDR_CTRL) begin
         ctrl <= PWDATA[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   a_powerup_idle: assert property ($rose(RST_N) |-> STANDBY)
      else $error("not in standby after power-up");
   a_deselect_start: assert property ($rose(RST_N) |-> !selected ##1 !selected)
      else $error("selected without a select falling edge");
   a_no_pause: assert property ($rose(RST_N) |-> !paused ##1 !paused)
      else $error("paused right after power-up");
   a_wel_clear: assert property ($rose(RST_N) |-> !write_enable_latch)
      else $error("write enable latch set after power-up");
   a_wip_clear: assert property ($rose(RST_N) |-> !WRITE_BUSY &&
      state == eeprom_pwr_pkg::ST_IDLE)
      else $error("write in progress after power-up");
   a_nv_hold: assert property (!nv_load |=> $stable(nv_bits))
      else $error("protection bits changed without a status write");
   a_write_launch: assert property (launch |-> starts_write(opcode, byte_cnt)
      ##1 WRITE_BUSY && !STANDBY)
      else $error("write cycle not launched");
   a_wel_gate: assert property (launch |-> write_enable_latch && $past(write_enable_latch))
      else $error("write launched without enable latch");
   a_done_clears: assert property (write_done |=> !write_enable_latch && !WRITE_BUSY)
      else $error("latch or busy left set after write cycle");

endmodule
`default_nettype wire

// [hw/nv_status_store.sv]
// Purpose: Non-volatile protection bits of the status register
// Assumes: Loaded only at the end of a status write cycle
// Notes:   No reset; initial value models the delivered part
`timescale 1ns/10ps
`default_nettype none

module nv_status_store (
   input  wire logic       clk,
   input  wire logic       load,
   input  wire logic [2:0] din,
   output logic [2:0]      bits
);

   // Factory state leaves the array unprotected
   logic [2:0] cells = eeprom_pwr_pkg::NV_FACTORY;

   // Kept across resets, only a completed write changes them
   always_ff @(posedge clk) begin
      if (load) begin
         cells <= din;
      end
   end

   assign bits = cells;

endmodule
`default_nettype wire

// [hw/spi_link_rx.sv]
// Purpose: Serial-clock side byte receiver
// Assumes: Mode 0 sampling on rising serial clock, chip select low active
// Notes:   Byte is held stable until the next byte, toggle marks each byte
`timescale 1ns/10ps
`default_nettype none

module spi_link_rx (
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   output logic [7:0]      rx_byte,
   output logic            rx_toggle
);

   logic [2:0] bit_cnt   = 3'h0;  // Known even if the first deselect edge is missed
   logic [6:0] shift     = 7'h00;
   logic [7:0] hold_byte = 8'h00;
   logic       tog       = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Bit position restarts whenever the master deselects
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt <= 3'h0;
         shift   <= 7'h00;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
         shift   <= {shift[5:0], mosi};
      end
   end

   // Toggle rather than pulse: the serial clock stops between frames
   always_ff @(posedge sck) begin
      if (!cs_n && bit_cnt == 3'h7) begin
         hold_byte <= {shift, mosi};
         tog       <= ~tog;
      end
   end

   assign rx_byte   = hold_byte;
   assign rx_toggle = tog;

endmodule
`default_nettype wire

// [sim/spi_master_model.sv]
// Purpose: SPI master model that sends one frame into the link per request
// Assumes: Mode 0, MSB first, first byte in frame[31:24]
// Notes:   Clock stands still and data toggles while deselected
`timescale 1ns/10ps
`default_nettype none

module spi_master_model (
   input  wire logic        lclk,
   input  wire logic        go,
   input  wire logic        slow,
   input  wire logic [2:0]  nbytes,
   input  wire logic [31:0] frame,
   output logic             sck,
   output logic             cs_n,
   output logic             mosi,
   output logic             busy
);
   int i;

   ////////////////////////////////////////
   // Frame engine; slow mode stretches each bit to two clocks
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge lclk);
         if (go) begin
            busy = 1'b1;
            cs_n = 1'b0;
            for (i = 0; i < nbytes * 8; i++) begin
               @(negedge lclk);
               sck = 1'b0;
               mosi = frame[31 - i];
               if (slow) @(negedge lclk);
               @(posedge lclk);
               sck = 1'b1;
            end
            @(negedge lclk);
            sck = 1'b0;
            @(negedge lclk);
            cs_n = 1'b1;
            busy = 1'b0;
         end else begin
            mosi = ~mosi; // Stale data never looks valid
         end
      end
   end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the EEPROM power-up sequencer
// Assumes: APB master on clk, SPI model on a 32 ns link clock
// Notes:   Write cycle shortened to WC clocks to keep the run short
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
   $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end

module tb_top;
   localparam int         WC   = 20;
   localparam logic [7:0] OPW  = 8'h02;
   localparam logic [7:0] OPS  = 8'h01;
   localparam logic [7:0] OPL  = 8'h06;
   localparam logic [7:0] OPC  = 8'h04;
   localparam logic [7:0] OPIW = 8'h82;
   localparam logic [7:0] OPIL = 8'h83;
   localparam logic [7:0] AST  = eeprom_pwr_pkg::ADDR_STATUS;
   logic        clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, hold_n = 1'b1;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, slow = 1'b0;
   logic [7:0]  paddr = 8'h00, nv = 8'h00, dat;
   logic [31:0] pwdata = 32'h0, frame = 32'h0, rd, prdata;
   logic [2:0]  nb = 3'h1;
   logic        pready, pslverr, standby, wbusy, sck, cs_n, mosi, mbusy, err;
   int          failures = 0, check_count = 0;

   ////////////////////////////////////////
   // Clocks, unrelated in phase
   always #12.5 clk = ~clk;
   initial #5 forever #16 lclk = ~lclk;

   eeprom_pwr_seq #(.WRITE_CYCLES(WC), .OP_WRITE(OPW), .OP_STAT_WR(OPS), .OP_LATCH_SET(OPL),
      .OP_LATCH_CLR(OPC), .OP_ID_WRITE(OPIW), .OP_ID_LOCK(OPIL)) dut_u (
      .REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SPI_SCK(sck),
      .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_HOLD_N(hold_n), .STANDBY(standby),
      .WRITE_BUSY(wbusy));
   spi_master_model spi_u (.lclk(lclk), .go(go), .slow(slow), .nbytes(nb), .frame(frame),
      .sck(sck), .cs_n(cs_n), .mosi(mosi), .busy(mbusy));

   ////////////////////////////////////////
   // Verdict and hang cut-off
   task automatic give_verdict;
      if (failures == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic bail;
      failures++;
      give_verdict();
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bail();
   end

   // APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) bail();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // One SPI frame through the model, then g idle clocks
   task automatic spi(input logic [2:0] b, input logic [31:0] f, input logic s, input int g);
      int k;
      @(posedge clk);
      nb <= b;
      frame <= f;
      slow <= s;
      go <= 1'b1;
      k = 0;
      while (mbusy !== 1'b1 && k < 50) begin
         @(posedge clk);
         k++;
      end
      if (k >= 50) bail();
      go <= 1'b0;
      while (mbusy !== 1'b0 && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (k >= 400) bail();
      repeat (g) @(posedge clk);
   endtask

   // Optional latch set, then a frame; count write-cycle clocks
   task automatic run(input logic [2:0] b, input logic [31:0] f, input logic lt, input logic ex);
      int k;
      int hi;
      if (lt) begin
         spi(3'h1, {OPL, 24'h0}, 1'b0, 8);
         apb(1'b0, AST, 32'h0);
         `CHK("wel_set", 1'b1, rd[eeprom_pwr_pkg::STAT_WEL])
      end
      spi(b, f, 1'($urandom_range(1)), 0);
      hi = 0;
      for (k = 0; k < WC + 40; k++) begin
         @(posedge clk);
         if (wbusy === 1'b1) hi++;
      end
      `CHK("busy_len", ex ? WC : 0, hi)
      if (ex) begin
         apb(1'b0, AST, 32'h0);
         `CHK("wel_done", 1'b0, rd[eeprom_pwr_pkg::STAT_WEL])
         apb(1'b0, eeprom_pwr_pkg::ADDR_LAST, 32'h0);
         `CHK("last_op", f[31:24], rd[7:0])
      end
   endtask

   // Power-up state of status word and pins
   task automatic up_chk;
      apb(1'b0, AST, 32'h0);
      `CHK("status", 32'h400 | {24'h0, nv}, rd & 32'h78F)
      `CHK("standby", 1'b1, standby)
      `CHK("wbusy", 1'b0, wbusy)
   endtask

   task automatic por;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   ////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(42107));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      up_chk();
      apb(1'b0, eeprom_pwr_pkg::ADDR_ARRAY, 32'h0);
      `CHK("array", 32'hFFFFFFFF, rd)
      apb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 1'b1, err)
      // Frames refused while acceptance is switched off
      apb(1'b1, eeprom_pwr_pkg::ADDR_CTRL, 32'h1);
      apb(1'b0, eeprom_pwr_pkg::ADDR_CTRL, 32'h0);
      `CHK("ctrl", 32'h1, rd)
      spi(3'h1, {OPL, 24'h0}, 1'b0, 8);
      apb(1'b0, AST, 32'h0);
      `CHK("no_accept", 1'b0, rd[eeprom_pwr_pkg::STAT_WEL])
      apb(1'b1, eeprom_pwr_pkg::ADDR_CTRL, 32'h3);
      apb(1'b1, AST, 32'hFFFFFFFF);
      up_chk();
      // Refusal without latch, then every write opcode
      run(3'h2, {OPS, 8'h8C, 16'h0}, 1'b0, 1'b0);
      dat = 8'h80 | (8'($urandom) & 8'h04);
      run(3'h2, {OPS, dat, 16'h0}, 1'b1, 1'b1);
      nv = dat & 8'h8C;
      run(3'h4, {OPW, 24'($urandom)}, 1'b1, 1'b1);
      run(3'h4, {OPIW, 24'($urandom)}, 1'b1, 1'b1);
      run(3'h4, {OPIL, 16'h0400, 8'h02}, 1'b1, 1'b1);
      run(3'h2, {OPW, 24'($urandom)}, 1'b1, 1'b0);
      spi(3'h1, {OPC, 24'h0}, 1'b0, 8);
      apb(1'b0, AST, 32'h0);
      `CHK("wel_clr", 1'b0, rd[eeprom_pwr_pkg::STAT_WEL])
      `CHK("nv_loaded", nv, rd[7:0] & 8'h8C)
      // Full protection refuses lock; latch left set for the reset
      run(3'h2, {OPS, 8'h0C, 16'h0}, 1'b1, 1'b1);
      nv = 8'h0C;
      run(3'h4, {OPIL, 16'h0400, 8'h02}, 1'b1, 1'b0);
      // Power lost in mid-frame: frame ignored, nv bits kept
      fork
         spi(3'h1, {OPL, 24'h0}, 1'b1, 10);
         begin
            repeat (3) @(posedge clk);
            por();
         end
      join
      up_chk();
      // Paused while selected, then power cycled with select still low
      hold_n <= 1'b0;
      fork
         spi(3'h4, {OPL, 24'h0}, 1'b1, 10);
         begin
            repeat (10) @(posedge clk);
            apb(1'b0, AST, 32'h0);
            `CHK("sel_pause", 3'b011, rd[10:8])
            por();
            repeat (2) @(posedge clk);
            apb(1'b0, AST, 32'h0);
            `CHK("after_por", 2'b00, rd[9:8])
         end
      join
      hold_n <= 1'b1;
      up_chk();
      give_verdict();
   end
endmodule
`default_nettype wire
